// ---- hdl/doic_pkg.sv ----
// constants, field layouts and mode types for the dual output interrupt controller
// ----------------------------------------------------------------------------
// Summary of operation
// [RL1] two blocks, each with select and flag; polarity and clear registers shared
// [RL2] enabled source event sets the same bit in that block's flag register
// [RL3] block a output goes to pin 0, 3 or 6; block b to 4 or 7
// [RL4] host configures the output pin before enabling any interrupt source
// [RL5] polarity bit 0: 0 falling edge, 1 rising edge; bits 31:1 read zero
// [RL6] a triggered enabled interrupt toggles the selected output pin
// [RL7] writing one to a clear bit clears that flag; clear reads undefined
// [RL8] four custom sources at bits 12:9 raised via generated status register
// [RL9] generated status register writes only from sequencer; host port writes ignored
// [RL10] eight external detectors: rise, fall, either edge, high or low level
// [RL11] edge modes give one pulse per qualifying transition
// [RL12] level modes hold the line while the input stays at the level
// [RL13] a detected external event wakes the device from hibernate
// [RL14] flag bits 0 to 8: adc, dft, sinc2, temp, min, max, delta, mean, variance
// [RL15] flag bits 13, 15, 16, 17: boot done, end of sequence, timeout, timeout error
// [RL16] flag bits 23 to 27: fifo full, empty, threshold, overflow, underflow
// [RL17] bit 29 outlier; bit 31 ignored second sequence request
// [RL18] both select registers reset to 0x00002000
// [RL19] both flag registers read-only, reset to zero
// [RL20] select bit 13 resets to one; each select bit enables its source
// [RL21] block active when any enabled flag is set; pin edge follows polarity
// ----------------------------------------------------------------------------
package doic_pkg;
    // ------------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------------
    localparam logic [15:0] ADDR_GEN_STATUS  = 16'h209C;
    localparam logic [15:0] ADDR_POLARITY    = 16'h3000;
    localparam logic [15:0] ADDR_CLEAR       = 16'h3004;
    localparam logic [15:0] ADDR_SELECT_A    = 16'h3008;
    localparam logic [15:0] ADDR_SELECT_B    = 16'h300C;
    localparam logic [15:0] ADDR_FLAGS_A     = 16'h3010;
    localparam logic [15:0] ADDR_FLAGS_B     = 16'h3014;

    // ------------------------------------------------------------------------
    // reset values and field layouts
    // ------------------------------------------------------------------------
    localparam logic [31:0] SELECT_RESET     = 32'h0000_2000;
    localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;
    localparam logic        POLARITY_RESET   = 1'h0;
    localparam logic [4:0]  GEN_STATUS_RESET = 5'h10;
    localparam int          GEN_WIDTH        = 5;
    localparam int          CUSTOM_LSB       = 9;
    localparam int          CUSTOM_COUNT     = 4;
    localparam int          POLARITY_BIT     = 0;
    // implemented source bits: 0..8, 9..12 custom, 13, 15..17, 23..27, 29, 31
    localparam logic [31:0] SOURCE_MASK      = 32'hAF83_BFFF;

    // ------------------------------------------------------------------------
    // output routing codes
    // ------------------------------------------------------------------------
    localparam logic [1:0]  ROUTE_A_PIN0     = 2'h0;
    localparam logic [1:0]  ROUTE_A_PIN3     = 2'h1;
    localparam logic [1:0]  ROUTE_A_PIN6     = 2'h2;
    localparam logic [1:0]  ROUTE_B_PIN4     = 2'h0;
    localparam logic [1:0]  ROUTE_B_PIN7     = 2'h1;
    localparam int          EXT_COUNT        = 8;
    localparam int          MODE_WIDTH       = 3;

    // external detector modes, fixed encoding since they arrive on ports
    localparam logic [2:0]  EXT_OFF          = 3'h0;
    localparam logic [2:0]  EXT_RISE         = 3'h1;
    localparam logic [2:0]  EXT_FALL         = 3'h2;
    localparam logic [2:0]  EXT_EITHER       = 3'h3;
    localparam logic [2:0]  EXT_HIGH         = 3'h4;
    localparam logic [2:0]  EXT_LOW          = 3'h5;
endpackage : doic_pkg

// ---- hdl/doic_ext_detect.sv ----
// one external interrupt detector with edge and level modes
`timescale 1ns/1ns
module doic_ext_detect (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_pin,
    input  wire logic [2:0] i_mode,
    output logic            o_irq
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic irq_next;

    // ------------------------------------------------------------------------
    // two stage synchroniser, pin is asynchronous
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= 1'h0;
            sync2_reg <= 1'h0;
            last_reg  <= 1'h0;
        end else begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    // ------------------------------------------------------------------------
    // detection
    // ------------------------------------------------------------------------
    always_comb begin
        case (i_mode)
            doic_pkg::EXT_RISE:   irq_next = sync2_reg & ~last_reg;   // [RL11]
            doic_pkg::EXT_FALL:   irq_next = ~sync2_reg & last_reg;   // [RL11]
            doic_pkg::EXT_EITHER: irq_next = sync2_reg ^ last_reg;    // [RL11]
            doic_pkg::EXT_HIGH:   irq_next = sync2_reg;               // [RL12]
            doic_pkg::EXT_LOW:    irq_next = ~sync2_reg;              // [RL12]
            default:              irq_next = 1'h0;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'h0;
        end else begin
            o_irq <= irq_next;                                        // [RL10]
        end
    end
endmodule : doic_ext_detect

// ---- hdl/doic_top.sv ----
// dual output interrupt controller: registers, flags, pin routing, external detectors
`timescale 1ns/1ns
module doic_top (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // register access port shared by host serial port and sequencer
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic        i_reg_from_seq,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    output logic             o_reg_rvalid,
    // internal source event pulses, bit n feeds flag n
    input  wire logic [31:0] i_src_event,
    // output routing
    input  wire logic [1:0]  i_route_a,
    input  wire logic [1:0]  i_route_b,
    output logic      [7:0]  o_gpio_out,
    output logic      [7:0]  o_gpio_oe,
    output logic             o_irq_out_a,
    output logic             o_irq_out_b,
    // external detectors
    input  wire logic [7:0]  i_ext_pin,
    input  wire logic [23:0] i_ext_mode,
    input  wire logic        i_hibernate,
    output logic      [7:0]  o_ext_irq,
    output logic             o_wake
);
    logic [31:0]                   select_a_reg;
    logic [31:0]                   select_b_reg;
    logic [31:0]                   flags_a_reg;
    logic [31:0]                   flags_b_reg;
    logic                          polarity_reg;
    logic [doic_pkg::GEN_WIDTH-1:0] gen_status_reg;
    logic [31:0]                   flags_a_next;
    logic [31:0]                   flags_b_next;
    logic [31:0]                   clear_bits;
    logic [31:0]                   raise_bits;
    logic [31:0]                   custom_bits;
    logic                          active_a;
    logic                          active_b;
    logic                          level_a;
    logic                          level_b;
    logic [7:0]                    gpio_out_next;
    logic [7:0]                    gpio_oe_next;
    logic [7:0]                    ext_hit;
    logic                          wr_seq_gen;
    logic [31:0]                   rdata_next;

    // ------------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------------
    // sequencer only: the host serial port cannot raise custom sources
    assign wr_seq_gen = i_reg_wr & i_reg_from_seq
                        & (i_reg_addr == doic_pkg::ADDR_GEN_STATUS);       // [RL9]

    always_comb begin
        clear_bits = '0;
        if (i_reg_wr && i_reg_addr == doic_pkg::ADDR_CLEAR) begin
            clear_bits = i_reg_wdata;                                       // [RL7]
        end
    end

    always_comb begin
        custom_bits = '0;
        if (wr_seq_gen) begin
            custom_bits[doic_pkg::CUSTOM_LSB +: doic_pkg::CUSTOM_COUNT] =
                i_reg_wdata[doic_pkg::CUSTOM_COUNT-1:0];                    // [RL8]
        end
    end

    // raw events laid out by bit position, reserved positions dropped
    assign raise_bits = (i_src_event | custom_bits) & doic_pkg::SOURCE_MASK; // [RL14] [RL15] [RL16] [RL17]

    // ------------------------------------------------------------------------
    // shared and per block configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            polarity_reg <= doic_pkg::POLARITY_RESET;
        end else if (i_reg_wr && i_reg_addr == doic_pkg::ADDR_POLARITY) begin
            polarity_reg <= i_reg_wdata[doic_pkg::POLARITY_BIT];            // [RL5]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            select_a_reg <= doic_pkg::SELECT_RESET;                         // [RL18] [RL20]
            select_b_reg <= doic_pkg::SELECT_RESET;                         // [RL18] [RL20]
        end else if (i_reg_wr) begin
            if (i_reg_addr == doic_pkg::ADDR_SELECT_A) begin
                select_a_reg <= i_reg_wdata;                                // [RL1]
            end
            if (i_reg_addr == doic_pkg::ADDR_SELECT_B) begin
                select_b_reg <= i_reg_wdata;                                // [RL1]
            end
        end
    end

    // generated status: custom bits act as strobes, upper bit is write one to clear
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            gen_status_reg <= doic_pkg::GEN_STATUS_RESET;
        end else if (wr_seq_gen) begin
            gen_status_reg <= gen_status_reg & ~i_reg_wdata[doic_pkg::GEN_WIDTH-1:0]; // [RL9]
        end
    end

    // ------------------------------------------------------------------------
    // flags: software cannot write them; set wins over a same cycle clear
    // ------------------------------------------------------------------------
    assign flags_a_next = (flags_a_reg & ~clear_bits) | (raise_bits & select_a_reg); // [RL2] [RL7]
    assign flags_b_next = (flags_b_reg & ~clear_bits) | (raise_bits & select_b_reg); // [RL2] [RL7]

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flags_a_reg <= doic_pkg::FLAGS_RESET;                           // [RL19]
            flags_b_reg <= doic_pkg::FLAGS_RESET;                           // [RL19]
        end else begin
            flags_a_reg <= flags_a_next;                                    // [RL1]
            flags_b_reg <= flags_b_next;                                    // [RL1]
        end
    end

    // ------------------------------------------------------------------------
    // block outputs and pin routing
    // ------------------------------------------------------------------------
    // disabling a select bit also masks a flag that is already pending
    assign active_a = |(flags_a_reg & select_a_reg);                        // [RL21] [RL20]
    assign active_b = |(flags_b_reg & select_b_reg);                        // [RL21] [RL20]
    // idle level is the opposite of the asserting edge
    assign level_a  = polarity_reg ? active_a : ~active_a;                  // [RL5] [RL6]
    assign level_b  = polarity_reg ? active_b : ~active_b;                  // [RL5] [RL6]

    // host must pick the route before enabling sources, else a stray edge
    always_comb begin
        gpio_out_next = '0;
        gpio_oe_next  = '0;
        case (i_route_a)
            doic_pkg::ROUTE_A_PIN0: begin
                gpio_out_next[0] = level_a;                                 // [RL3]
                gpio_oe_next[0]  = 1'h1;
            end
            doic_pkg::ROUTE_A_PIN3: begin
                gpio_out_next[3] = level_a;                                 // [RL3]
                gpio_oe_next[3]  = 1'h1;
            end
            doic_pkg::ROUTE_A_PIN6: begin
                gpio_out_next[6] = level_a;                                 // [RL3]
                gpio_oe_next[6]  = 1'h1;
            end
            default: begin
            end
        endcase
        case (i_route_b)
            doic_pkg::ROUTE_B_PIN4: begin
                gpio_out_next[4] = level_b;                                 // [RL3]
                gpio_oe_next[4]  = 1'h1;
            end
            doic_pkg::ROUTE_B_PIN7: begin
                gpio_out_next[7] = level_b;                                 // [RL3]
                gpio_oe_next[7]  = 1'h1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_gpio_out  <= '0;
            o_gpio_oe   <= '0;
            o_irq_out_a <= 1'h0;
            o_irq_out_b <= 1'h0;
        end else begin
            o_gpio_out  <= gpio_out_next;                                   // [RL6]
            o_gpio_oe   <= gpio_oe_next;
            o_irq_out_a <= level_a;
            o_irq_out_b <= level_b;
        end
    end

    // ------------------------------------------------------------------------
    // external detectors and wake
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < doic_pkg::EXT_COUNT; g++) begin : g_ext
            doic_ext_detect u_det (
                .i_clock (i_clock),
                .i_rst   (i_rst),
                .i_pin   (i_ext_pin[g]),
                .i_mode  (i_ext_mode[g*doic_pkg::MODE_WIDTH +: doic_pkg::MODE_WIDTH]),
                .o_irq   (ext_hit[g])
            );                                                              // [RL10]
        end
    endgenerate

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ext_irq <= '0;
            o_wake    <= 1'h0;
        end else begin
            o_ext_irq <= ext_hit;
            o_wake    <= i_hibernate & (|ext_hit);                          // [RL13]
        end
    end

    // ------------------------------------------------------------------------
    // read path, one cycle latency
    // ------------------------------------------------------------------------
    always_comb begin
        case (i_reg_addr)
            doic_pkg::ADDR_POLARITY:   rdata_next = {31'h0, polarity_reg};  // [RL5]
            doic_pkg::ADDR_SELECT_A:   rdata_next = select_a_reg;
            doic_pkg::ADDR_SELECT_B:   rdata_next = select_b_reg;
            doic_pkg::ADDR_FLAGS_A:    rdata_next = flags_a_reg;
            doic_pkg::ADDR_FLAGS_B:    rdata_next = flags_b_reg;
            doic_pkg::ADDR_GEN_STATUS: rdata_next = {27'h0, gen_status_reg};
            // clear register has no readable content, zero chosen
            default:                   rdata_next = 32'h0000_0000;          // [RL7]
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata  <= '0;
            o_reg_rvalid <= 1'h0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_next;
            end
        end
    end
endmodule : doic_top

// ---- test/doic_checker.sv ----
// port-level assertion checker for the dual output interrupt controller
`timescale 1ns/1ns
module doic_checker (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic        i_reg_from_seq,
    input wire logic [15:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic [31:0] i_src_event,
    input wire logic [1:0]  i_route_a,
    input wire logic [1:0]  i_route_b,
    input wire logic [7:0]  o_gpio_out,
    input wire logic [7:0]  o_gpio_oe,
    input wire logic        o_irq_out_a,
    input wire logic        o_irq_out_b,
    input wire logic [7:0]  i_ext_pin,
    input wire logic [23:0] i_ext_mode,
    input wire logic        i_hibernate,
    input wire logic [7:0]  o_ext_irq,
    input wire logic        o_wake
);
    // ------------------------------------------------------------------------
    // shadow of block a select and polarity, rebuilt from the write strobes
    // ------------------------------------------------------------------------
    logic [31:0] sel_a_reg;
    logic        pol_reg;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_a_reg <= doic_pkg::SELECT_RESET;
            pol_reg   <= 1'h0;
        end else if (i_reg_wr && i_reg_addr == doic_pkg::ADDR_SELECT_A) begin
            sel_a_reg <= i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == doic_pkg::ADDR_POLARITY) begin
            pol_reg <= i_reg_wdata[0];
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_read_answer: assert property (o_reg_rvalid == $past(i_reg_rd))
        else $error("read answer not a single pulse");
    a_clear_reads: assert property (i_reg_rd && i_reg_addr == doic_pkg::ADDR_CLEAR |=> o_reg_rdata == 32'h0)
        else $error("clear register read not zero");
    a_pol_reserved: assert property (i_reg_rd && i_reg_addr == doic_pkg::ADDR_POLARITY |=> o_reg_rdata[31:1] == 31'h0)
        else $error("polarity reserved bits set");
    a_flag_reserved: assert property (i_reg_rd && i_reg_addr[15:4] == 12'h301 |=> !(o_reg_rdata & ~doic_pkg::SOURCE_MASK))
        else $error("reserved flag bit set");
    a_event_asserts: assert property (|(i_src_event & sel_a_reg) |-> ##2 o_irq_out_a == pol_reg)
        else $error("enabled event did not assert output a");
    a_custom_asserts: assert property (i_reg_wr && i_reg_from_seq && i_reg_addr == doic_pkg::ADDR_GEN_STATUS
        && |(i_reg_wdata[3:0] & sel_a_reg[12:9]) |-> ##2 o_irq_out_a == pol_reg)
        else $error("custom source did not assert output a");
    a_clear_idles: assert property (i_reg_wr && i_reg_addr == doic_pkg::ADDR_CLEAR && &i_reg_wdata && !i_src_event
        ##1 (!i_reg_wr && !i_src_event) |=> o_irq_out_a != pol_reg && o_irq_out_b != pol_reg)
        else $error("outputs not idle after clear");
    a_pins_follow: assert property ((o_gpio_out & ~o_gpio_oe) == 8'h0 && (o_gpio_oe & 8'h26) == 8'h0
        && (!o_gpio_oe[3] || o_gpio_out[3] == o_irq_out_a) && (!o_gpio_oe[7] || o_gpio_out[7] == o_irq_out_b))
        else $error("pin level does not follow block output");
    a_route_pin: assert property (1'b1 |=> o_gpio_oe[7] == ($past(i_route_b) == doic_pkg::ROUTE_B_PIN7))
        else $error("block b pin routing wrong");
    a_edge_pulse: assert property (o_ext_irq[1] && i_ext_mode[5:3] == doic_pkg::EXT_RISE |=> !o_ext_irq[1])
        else $error("edge detector output longer than one cycle");
    a_level_hold: assert property ((i_ext_mode[14:12] == doic_pkg::EXT_HIGH && i_ext_pin[4]) [*5] |=> o_ext_irq[4])
        else $error("level detector output not held");
    a_wake_event: assert property (o_wake == ($past(i_hibernate) && |o_ext_irq))
        else $error("wake does not match detected event");
endmodule : doic_checker
bind doic_top doic_checker doic_checker_i (.*);

// ---- test/doic_host_model.sv ----
// host model counting interrupt edges seen on one routed pin
`timescale 1ns/1ns
module doic_host_model (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_pin,
    input  wire logic i_rising,
    output int        o_edges
);
    logic last_reg;
    // only the edge of the chosen polarity alerts the host
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            last_reg <= 1'h1;
            o_edges  <= 0;
        end else begin
            last_reg <= i_pin;
            if (i_rising ? (i_pin && !last_reg) : (!i_pin && last_reg)) begin
                o_edges <= o_edges + 1;
            end
        end
    end
endmodule : doic_host_model

// ---- test/tb_top.sv ----
// self-checking testbench for the dual output interrupt controller
`timescale 1ns/1ns
module tb_top;
    logic        i_clock, i_rst, i_reg_wr, i_reg_rd, i_reg_from_seq, i_hibernate;
    logic [15:0] i_reg_addr;
    logic [31:0] i_reg_wdata, i_src_event, o_reg_rdata;
    logic [1:0]  i_route_a, i_route_b;
    logic [7:0]  i_ext_pin, o_gpio_out, o_gpio_oe, o_ext_irq;
    logic [23:0] i_ext_mode;
    logic        o_reg_rvalid, o_irq_out_a, o_irq_out_b, o_wake, count_on;
    int          mismatches, check_count, cycles, host_edges, e0;
    int          pulses [4] = '{0, 0, 0, 0};
    // pull-up on the pin while the block does not drive it
    wire logic   pin_a = o_gpio_oe[3] ? o_gpio_out[3] : 1'b1;
    doic_top doic_top_i (.i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_from_seq(i_reg_from_seq), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_src_event(i_src_event),
        .i_route_a(i_route_a), .i_route_b(i_route_b), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe),
        .o_irq_out_a(o_irq_out_a), .o_irq_out_b(o_irq_out_b), .i_ext_pin(i_ext_pin),
        .i_ext_mode(i_ext_mode), .i_hibernate(i_hibernate), .o_ext_irq(o_ext_irq), .o_wake(o_wake));
    doic_host_model doic_host_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_pin(pin_a),
        .i_rising(1'b1), .o_edges(host_edges));
    initial begin
        i_clock = 1'h0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (count_on) for (int g = 0; g < 4; g++) pulses[g] += o_ext_irq[g];
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report;
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask : tick
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic s);
        i_reg_wr = 1'h1;
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_from_seq = s;
        tick();
        i_reg_wr = 1'h0;
        i_reg_from_seq = 1'h0;
        tick();
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        i_reg_rd = 1'h1;
        i_reg_addr = a;
        tick();
        i_reg_rd = 1'h0;
        cmp({31'h0, o_reg_rvalid}, 32'h1);
        cmp(o_reg_rdata, exp);
        tick();
    endtask : rd
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rd(doic_pkg::ADDR_SELECT_A, 32'h0000_2000);
        rd(doic_pkg::ADDR_SELECT_B, 32'h0000_2000);
        rd(doic_pkg::ADDR_FLAGS_A, 32'h0);
        rd(doic_pkg::ADDR_FLAGS_B, 32'h0);
        rd(doic_pkg::ADDR_POLARITY, 32'h0);
        rd(doic_pkg::ADDR_GEN_STATUS, 32'h10);
        cmp({16'h0, o_gpio_oe, o_gpio_out}, 32'h8888);
        i_route_a = doic_pkg::ROUTE_A_PIN0;
        i_route_b = doic_pkg::ROUTE_B_PIN4;
        tick();
        cmp({16'h0, o_gpio_oe, o_gpio_out}, 32'h1111);
        i_route_a = doic_pkg::ROUTE_A_PIN6;
        i_route_b = 2'h2;
        tick();
        cmp({16'h0, o_gpio_oe, o_gpio_out}, 32'h4040);
        i_route_a = doic_pkg::ROUTE_A_PIN3;
        i_route_b = doic_pkg::ROUTE_B_PIN7;
        tick();
        // boot done source is enabled from reset; polarity 0 asserts low
        i_src_event = 32'h0000_2000;
        tick();
        i_src_event = 32'h0;
        tick();
        cmp({o_irq_out_a, o_irq_out_b}, 2'h0);
        wr(doic_pkg::ADDR_CLEAR, 32'h0000_2000, 1'h0);
        cmp({o_irq_out_a, o_irq_out_b}, 2'h3);
    endtask : t_reset
    task automatic t_flags;
        wr(doic_pkg::ADDR_POLARITY, 32'hFFFF_FFFF, 1'h0);
        rd(doic_pkg::ADDR_POLARITY, 32'h1);
        wr(doic_pkg::ADDR_SELECT_A, 32'hFFFF_FFFF, 1'h0);
        wr(doic_pkg::ADDR_SELECT_B, 32'h1, 1'h0);
        e0 = host_edges;
        i_src_event = 32'hFFFF_FFFF;
        tick();
        i_src_event = 32'h0;
        tick();
        rd(doic_pkg::ADDR_FLAGS_A, 32'hAF83_BFFF);
        rd(doic_pkg::ADDR_FLAGS_B, 32'h1);
        cmp(host_edges - e0, 1);
        wr(doic_pkg::ADDR_FLAGS_A, 32'h0, 1'h0);
        rd(doic_pkg::ADDR_FLAGS_A, 32'hAF83_BFFF);
        wr(doic_pkg::ADDR_CLEAR, 32'h1, 1'h0);
        rd(doic_pkg::ADDR_FLAGS_B, 32'h0);
        rd(doic_pkg::ADDR_FLAGS_A, 32'hAF83_BFFE);
        cmp({o_irq_out_a, o_irq_out_b}, 2'h2);
        rd(doic_pkg::ADDR_CLEAR, 32'h0);
        wr(doic_pkg::ADDR_SELECT_A, 32'h0, 1'h0);
        tick();
        cmp(o_irq_out_a, 1'h0);
        wr(doic_pkg::ADDR_CLEAR, 32'hFFFF_FFFF, 1'h0);
        tick();
    endtask : t_flags
    task automatic t_custom;
        wr(doic_pkg::ADDR_SELECT_A, 32'h0000_1E00, 1'h0);
        wr(doic_pkg::ADDR_GEN_STATUS, 32'h1F, 1'h0);
        rd(doic_pkg::ADDR_FLAGS_A, 32'h0);
        rd(doic_pkg::ADDR_GEN_STATUS, 32'h10);
        wr(doic_pkg::ADDR_GEN_STATUS, 32'h1F, 1'h1);
        rd(doic_pkg::ADDR_FLAGS_A, 32'h0000_1E00);
        rd(doic_pkg::ADDR_GEN_STATUS, 32'h0);
        cmp(o_irq_out_a, 1'h1);
        wr(doic_pkg::ADDR_CLEAR, 32'hFFFF_FFFF, 1'h0);
        tick();
    endtask : t_custom
    task automatic t_ext;
        i_hibernate = 1'h1;
        count_on = 1'h1;
        i_ext_pin = 8'hFF;
        repeat (8) tick();
        cmp(o_ext_irq, 8'h10);
        i_ext_pin = 8'h00;
        repeat (8) tick();
        cmp(o_ext_irq, 8'h20);
        count_on = 1'h0;
        cmp({pulses[3][7:0], pulses[2][7:0], pulses[1][7:0], pulses[0][7:0]}, 32'h0201_0100);
        cmp(o_wake, 1'h1);
        i_hibernate = 1'h0;
        repeat (2) tick();
        cmp(o_wake, 1'h0);
    endtask : t_ext
    initial begin
        {i_reg_wr, i_reg_rd, i_reg_from_seq, i_hibernate, count_on} = 5'h0;
        {i_reg_addr, i_reg_wdata, i_src_event, i_ext_pin} = 88'h0;
        i_route_a = doic_pkg::ROUTE_A_PIN3; // routed before any enable
        i_route_b = doic_pkg::ROUTE_B_PIN7;
        // detector g runs mode g; 6 and 7 are unknown codes that stay off
        i_ext_mode = {3'h7, 3'h6, doic_pkg::EXT_LOW, doic_pkg::EXT_HIGH, doic_pkg::EXT_EITHER,
            doic_pkg::EXT_FALL, doic_pkg::EXT_RISE, doic_pkg::EXT_OFF};
        i_rst = 1'h1;
        repeat (12) @(posedge i_clock);
        #1;
        i_rst = 1'h0;
        tick();
        t_reset();
        t_flags();
        t_custom();
        t_ext();
        final_report();
    end
endmodule : tb_top
